// ### hw/dalu_conv.v
// Shared binary/BCD conversion tables
`timescale 1ns/100ps
module dalu_conv (
  // Inputs
  input wire [6:0] bin7,
  input wire [15:0] bcd,
  input wire dtb_sel,
  // Result
  output wire [15:0] out
);
  wire [6:0] rem;
  wire [6:0] tens;
  wire [6:0] ones;
  wire [13:0] low_bin;
  wire [13:0] high_bin;
  assign rem = (bin7 > 7'd99) ? bin7 - 7'd100 : bin7;
  assign tens = rem / 7'd10;
  assign ones = rem % 7'd10;
  assign low_bin = {10'h000, bcd[7:4]} * 14'd10 + {10'h000, bcd[3:0]}; // [RQ11]
  assign high_bin = {10'h000, bcd[15:12]} * 14'd1000 + {10'h000, bcd[11:8]} * 14'd100; // [RQ12]
  // Inactive select means binary to decimal
  // Remainder below 100, so both digits fit a nibble
  assign out = dtb_sel ? {2'b00, low_bin + high_bin} : {8'h00, tens[3:0], ones[3:0]}; // [RQ9] [RQ10]
endmodule // dalu_conv

// ### hw/dalu_nib.v
// One nibble of the decimal adder with excess-6 removal
`timescale 1ns/100ps
module dalu_nib (
  // Operands
  input wire [3:0] a,
  input wire [3:0] b,
  input wire cin,
  // Results
  output wire [3:0] sum,
  output wire cout,
  output wire [3:0] fix
);
  wire [4:0] full;
  assign full = {1'b0, a} + {1'b0, b} + {4'h0, cin};
  assign sum = full[3:0];
  assign cout = full[4];
  // No carry out means the bias is still in the digit
  assign fix = cout ? full[3:0] : full[3:0] - 4'h6; // [RQ24]
endmodule // dalu_nib

// ### hw/dalu_top.v
// Decimal ALU assist: APB registers, decimal merge modes, bias logic, shortening
//
// Behaviour
// (RQ1) Link output needs link and tracked nibble match
// (RQ2) Alignment code picks which nibbles are tracked
// (RQ3) Unpack zone is hex B, or 3 in 7-bit
// (RQ4) Mode field selects the four decimal modes
// (RQ5) Alignment shift passes B, or A when set
// (RQ6) Merge takes leading N nibbles from A
// (RQ7) Packed unload places A at destination window
// (RQ8) Unpacked unload uses same selection per byte
// (RQ9) Binary-to-decimal maps result bits 9-15 to BCD; the code converts result_r[7:1]
// (RQ10) Inactive decimal-to-binary select means binary-to-decimal
// (RQ11) Active select converts low two digits to binary
// (RQ12) Upper digits give hundreds; sum gives full binary
// (RQ13) Pack four character digits into sixteen bits
// (RQ14) Excess-6 bias added before add, removed after
// (RQ15) Unpack to characters in same step as removal
// (RQ16) Negative differential shortens destination, positive source
// (RQ17) Nonzero digit lost from destination flags not-equal
// (RQ18) Subtract borrows when skipped source digit nonzero
// (RQ19) Source shorten updates length, pointer, alignment flops
// (RQ20) Destination shorten moves only its pointer
// (RQ21) Align flops hold destination, source, length codes
// (RQ22) One add operation, sign controls give subtraction
// (RQ23) Per-nibble detects NANDed into zero tracking flag
// (RQ24) Nibbles without carry lose six, others kept
// (RQ25) Unpacked unload, zero codes, zero length: all A
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "dalu_regs.vh"
module dalu_top (
  // APB clock and reset
  input wire pclk,
  input wire presetn,
  // APB request
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  // APB answer
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Datapath status
  output reg zero_track_flag,
  output reg link_out
);
  // ==========================================================
  // Registers
  reg [14:0] ctrl_r;
  reg [31:0] opa_r;
  reg [31:0] opb_r;
  reg [31:0] result_r;
  reg carry_r;
  reg cc_ne_r;
  reg borrow_r;
  reg [15:0] conv_r;
  reg [7:0] src_len_r;
  reg [7:0] src_ptr_r;
  reg [7:0] dst_ptr_r;
  reg [7:0] dst_len_r;

  wire [2:0] alu_mode_field;
  wire [1:0] dst_align;
  wire [1:0] src_align;
  wire [1:0] len_code;
  wire link_in;
  wire char7;
  wire shift_leg_select;
  wire dec_to_bin_select;
  // Align flops: destination, source, then length pair
  assign alu_mode_field = ctrl_r[`DALU_CTRL_MODE_LO +: 3];
  assign dst_align = ctrl_r[`DALU_CTRL_DST_LO +: 2]; // [RQ21]
  assign src_align = ctrl_r[`DALU_CTRL_SRC_LO +: 2]; // [RQ21]
  assign len_code = ctrl_r[`DALU_CTRL_LEN_LO +: 2]; // [RQ21]
  assign link_in = ctrl_r[`DALU_CTRL_LINK];
  assign char7 = ctrl_r[`DALU_CTRL_CHAR7];
  assign shift_leg_select = ctrl_r[`DALU_CTRL_SHIFT_LEG];
  assign dec_to_bin_select = ctrl_r[`DALU_CTRL_DTB];

  // ==========================================================
  // APB decode
  wire setup_ph;
  wire access_ph;
  wire wr_en;
  reg mapped;
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable & pready;
  assign wr_en = access_ph & pwrite & mapped;

  always @* begin
    case (paddr)
      `DALU_OFF_CTRL, `DALU_OFF_CMD, `DALU_OFF_OPA, `DALU_OFF_OPB,
      `DALU_OFF_RESULT, `DALU_OFF_STATUS, `DALU_OFF_CONV,
      `DALU_OFF_PTRS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  wire cmd_wr;
  wire exec_go;
  wire shorten_go;
  wire [2:0] skip_k;
  assign cmd_wr = wr_en && (paddr == `DALU_OFF_CMD);
  assign exec_go = cmd_wr & pwdata[`DALU_CMD_EXEC];
  assign shorten_go = cmd_wr & pwdata[`DALU_CMD_SHORTEN];
  assign skip_k = pwdata[`DALU_CMD_K_LO +: 3];

  // ==========================================================
  // Adder with optional excess-6 bias on the B leg
  wire [15:0] add_b;
  wire [15:0] sum16;
  wire [15:0] fix16;
  wire [4:0] nib_c;
  // Bias lets decimal carries fall out of binary nibble adds
  assign add_b = ctrl_r[`DALU_CTRL_BIAS] ? `DALU_BIAS6 : opb_r[15:0]; // [RQ14]
  // Subtraction is software-complemented operand plus carry-in
  assign nib_c[0] = ctrl_r[`DALU_CTRL_CIN]; // [RQ22]

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_nib
      dalu_nib u_nib (
        .a(opa_r[4*g +: 4]),
        .b(add_b[4*g +: 4]),
        .cin(nib_c[g]),
        .sum(sum16[4*g +: 4]),
        .cout(nib_c[g+1]),
        .fix(fix16[4*g +: 4])
      );
    end
  endgenerate

  // ==========================================================
  // Nibble selection for decimal merge modes
  // Bit 3 of sel_a is the leftmost nibble (position 1)
  reg [3:0] sel_a;
  reg [2:0] merge_n;
  reg [2:0] win_p;
  reg [3:0] pos;
  integer i;
  always @* begin
    sel_a = 4'h0;
    merge_n = {1'b0, src_align - dst_align}; // [RQ6]
    win_p = {1'b0, dst_align} + 3'h1;
    pos = 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
      pos = 4'd4 - i[3:0];
      case (alu_mode_field)
        `DALU_M_ADJ: sel_a[i] = shift_leg_select; // [RQ4] [RQ5]
        `DALU_M_MERGE: sel_a[i] = (pos <= {1'b0, merge_n}); // [RQ4] [RQ6]
        `DALU_M_UNLP, `DALU_M_UNLU: begin
          // Zero length takes all of A; window clips at nibble one
          if (len_code == 2'b00) begin
            sel_a[i] = 1'b1; // [RQ7] [RQ25]
          end else begin
            sel_a[i] = (pos <= {1'b0, win_p}) &&
                       (pos + {2'b00, len_code} > {1'b0, win_p}); // [RQ4] [RQ7] [RQ8]
          end
        end
        default: sel_a[i] = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Result mux
  reg [31:0] res_nxt;
  reg carry_nxt;
  wire [3:0] zone;
  assign zone = char7 ? `DALU_ZONE7 : `DALU_ZONE8; // [RQ3]
  integer j;
  always @* begin
    res_nxt = 32'h00000000;
    carry_nxt = carry_r;
    case (alu_mode_field)
      `DALU_M_ADD: begin
        res_nxt = {16'h0000, sum16};
        carry_nxt = nib_c[4];
      end
      `DALU_M_FIXP: begin
        res_nxt = {16'h0000, fix16}; // [RQ14] [RQ24]
        carry_nxt = nib_c[4];
      end
      `DALU_M_FIXU: begin
        // Removal and expansion share the step
        res_nxt = {zone, fix16[15:12], zone, fix16[11:8],
                   zone, fix16[7:4], zone, fix16[3:0]}; // [RQ15] [RQ3]
        carry_nxt = nib_c[4];
      end
      `DALU_M_PACK: begin
        // Only the character zone bits are dropped
        res_nxt = {16'h0000, opa_r[27:24], opa_r[19:16],
                   opa_r[11:8], opa_r[3:0]}; // [RQ13]
      end
      `DALU_M_UNLU: begin
        for (j = 0; j < 4; j = j + 1) begin
          res_nxt[8*j +: 8] = sel_a[j] ? opa_r[8*j +: 8] : opb_r[8*j +: 8]; // [RQ8]
        end
      end
      default: begin
        for (j = 0; j < 4; j = j + 1) begin
          res_nxt[4*j +: 4] = sel_a[j] ? opa_r[4*j +: 4] : opb_r[4*j +: 4];
        end
      end
    endcase
  end

  // ==========================================================
  // Zero tracking on the stored result and carry
  reg [3:0] nibble_nonzero_detect;
  reg [3:0] tracked;
  wire [15:0] high_alu_result;
  wire high_alu_carry_out;
  assign high_alu_result = result_r[15:0];
  assign high_alu_carry_out = carry_r;
  integer k;
  always @* begin
    case (dst_align)
      2'b00: tracked = 4'hf; // [RQ2]
      2'b11: tracked = 4'h7; // [RQ2]
      default: tracked = 4'h3; // [RQ2]
    endcase
    for (k = 0; k < 4; k = k + 1) begin
      // Untracked nibbles never veto
      nibble_nonzero_detect[k] = link_in & (~tracked[k] |
        (high_alu_carry_out ? (high_alu_result[4*k +: 4] == 4'h0)
                            : (high_alu_result[4*k +: 4] == 4'h6))); // [RQ1]
    end
  end

  // ==========================================================
  // Conversion tables
  wire [15:0] conv_out;
  dalu_conv u_conv (
    .bin7(result_r[7:1]),
    .bcd(result_r[15:0]),
    .dtb_sel(dec_to_bin_select),
    .out(conv_out)
  );

  // ==========================================================
  // Shortening: skipped digits come from the low nibbles of A
  reg [15:0] skip_mask;
  wire skip_nz;
  wire [7:0] k8;
  always @* begin
    case (skip_k)
      3'h0: skip_mask = 16'h0000;
      3'h1: skip_mask = 16'h000f;
      3'h2: skip_mask = 16'h00ff;
      3'h3: skip_mask = 16'h0fff;
      default: skip_mask = 16'hffff;
    endcase
  end
  assign skip_nz = |(opa_r[15:0] & skip_mask);
  assign k8 = {5'h00, skip_k};

  // ==========================================================
  // Register writes and datapath updates
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `DALU_CTRL_RESET;
      opa_r <= 32'h00000000;
      opb_r <= 32'h00000000;
      result_r <= 32'h00000000;
      carry_r <= 1'b0;
      cc_ne_r <= 1'b0;
      borrow_r <= 1'b0;
      conv_r <= 16'h0000;
      {dst_len_r, dst_ptr_r, src_ptr_r, src_len_r} <= `DALU_PTRS_RESET;
    end else begin
      conv_r <= conv_out;
      if (wr_en && paddr == `DALU_OFF_CTRL) begin
        ctrl_r <= pwdata[14:0];
      end
      if (wr_en && paddr == `DALU_OFF_OPA) begin
        opa_r <= pwdata;
      end
      if (wr_en && paddr == `DALU_OFF_OPB) begin
        opb_r <= pwdata;
      end
      if (wr_en && paddr == `DALU_OFF_PTRS) begin
        {dst_len_r, dst_ptr_r, src_ptr_r, src_len_r} <= pwdata;
      end
      if (exec_go) begin
        result_r <= res_nxt;
        carry_r <= carry_nxt;
      end
      // Clear first so a same-cycle event wins
      if (cmd_wr && pwdata[`DALU_CMD_CLR]) begin
        cc_ne_r <= 1'b0;
        borrow_r <= 1'b0;
      end
      if (shorten_go) begin
        if (pwdata[`DALU_CMD_NEG]) begin
          dst_ptr_r <= dst_ptr_r - k8; // [RQ16] [RQ20]
          if (skip_nz) begin
            cc_ne_r <= 1'b1; // [RQ17]
          end
        end else begin
          src_len_r <= src_len_r - k8; // [RQ16] [RQ19]
          src_ptr_r <= src_ptr_r - k8; // [RQ19]
          ctrl_r[`DALU_CTRL_SRC_LO +: 2] <= src_align - skip_k[1:0]; // [RQ19]
          if (pwdata[`DALU_CMD_SUB] && skip_nz) begin
            borrow_r <= 1'b1; // [RQ18]
          end
        end
      end
    end
  end

  // ==========================================================
  // Status outputs, registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_track_flag <= 1'b1;
      link_out <= 1'b0;
    end else begin
      zero_track_flag <= ~&nibble_nonzero_detect; // [RQ23]
      link_out <= &nibble_nonzero_detect; // [RQ1]
    end
  end

  // ==========================================================
  // APB read data and handshake; no wait state, data is flopped in the setup phase
  reg [31:0] rd_nxt;
  always @* begin
    case (paddr)
      `DALU_OFF_CTRL: rd_nxt = {17'h00000, ctrl_r};
      `DALU_OFF_OPA: rd_nxt = opa_r;
      `DALU_OFF_OPB: rd_nxt = opb_r;
      `DALU_OFF_RESULT: rd_nxt = result_r;
      `DALU_OFF_STATUS: rd_nxt = {27'h0000000, borrow_r, cc_ne_r,
                                  zero_track_flag, link_out, carry_r};
      `DALU_OFF_CONV: rd_nxt = {16'h0000, conv_r};
      `DALU_OFF_PTRS: rd_nxt = {dst_len_r, dst_ptr_r, src_ptr_r, src_len_r};
      default: rd_nxt = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph & ~mapped;
      if (setup_ph && !pwrite) begin
        prdata <= rd_nxt;
      end
    end
  end
endmodule // dalu_top

// ### pkg/dalu_regs.vh
// Register map, field positions, reset values and mode codes of the decimal ALU assist
`ifndef DALU_REGS_VH
`define DALU_REGS_VH
// ==========================================================
// Register byte offsets
`define DALU_OFF_CTRL 8'h00
`define DALU_OFF_CMD 8'h04
`define DALU_OFF_OPA 8'h08
`define DALU_OFF_OPB 8'h0c
`define DALU_OFF_RESULT 8'h10
`define DALU_OFF_STATUS 8'h14
`define DALU_OFF_CONV 8'h18
`define DALU_OFF_PTRS 8'h1c
// ==========================================================
// Control fields
`define DALU_CTRL_MODE_LO 0
`define DALU_CTRL_LINK 3
`define DALU_CTRL_CHAR7 4
`define DALU_CTRL_SHIFT_LEG 5
`define DALU_CTRL_BIAS 6
`define DALU_CTRL_CIN 7
`define DALU_CTRL_DST_LO 8
`define DALU_CTRL_SRC_LO 10
`define DALU_CTRL_LEN_LO 12
`define DALU_CTRL_DTB 14
`define DALU_CTRL_RESET 15'h0000
// ==========================================================
// Command fields
`define DALU_CMD_EXEC 0
`define DALU_CMD_SHORTEN 1
`define DALU_CMD_SUB 3
`define DALU_CMD_K_LO 4
`define DALU_CMD_NEG 7
`define DALU_CMD_CLR 8
// ==========================================================
// Status fields
`define DALU_ST_CARRY 0
`define DALU_ST_LINK 1
`define DALU_ST_ZTRACK 2
`define DALU_ST_CCNE 3
`define DALU_ST_BORROW 4
// ==========================================================
// ALU mode codes
`define DALU_M_ADD 3'h0
`define DALU_M_FIXP 3'h1
`define DALU_M_FIXU 3'h2
`define DALU_M_PACK 3'h3
`define DALU_M_ADJ 3'h4
`define DALU_M_MERGE 3'h5
`define DALU_M_UNLP 3'h6
`define DALU_M_UNLU 3'h7
// ==========================================================
// Constants
`define DALU_BIAS6 16'h6666
`define DALU_ZONE8 4'hb
`define DALU_ZONE7 4'h3
`define DALU_PTRS_RESET 32'h00000000
`endif

// ### testbench/dalu_seq_model.sv
// Bus master model standing in for the microsequencer
`timescale 1ns/100ps
module dalu_seq_model (
  // Clock
  input wire logic pclk,
  // APB request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // APB answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  int idle = 0;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // ==========================================================
  // One transfer; idle cycles make a slow master
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    repeat (idle) @(posedge pclk);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data must not keep showing the last value
    pwdata <= ~d;
    paddr <= ~a;
  endtask
endmodule // dalu_seq_model

// ### testbench/dalu_top_checker.sv
// Port-level assertions for the decimal ALU assist
`timescale 1ns/100ps
`include "dalu_regs.vh"
module dalu_top_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // APB answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Datapath status
  input wire logic zero_track_flag,
  input wire logic link_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Control shadow; source align bits skipped, shortening moves them
  reg [14:0] ctrl_r;
  wire acc = psel && penable && pready;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctrl_r <= 15'h0000;
    else if (acc && pwrite && paddr == `DALU_OFF_CTRL)
      ctrl_r <= pwdata[14:0];
  end
  // ==========================================================
  // Assertions
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  chk_err_unmapped: assert property (acc && paddr > 8'h1c |-> pslverr)
    else $error("unmapped access not refused");
  chk_ok_mapped: assert property (acc && paddr <= 8'h1c && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  chk_err_rdzero: assert property (pslverr && !pwrite |-> prdata == 32'h00000000)
    else $error("refused read returned data");
  chk_link_low: assert property (!ctrl_r[3] && !$past(ctrl_r[3]) |-> !link_out)
    else $error("link output high with link input low");
  chk_ztrack_nand: assert property (zero_track_flag == !link_out)
    else $error("zero tracking not nand of detects");
  chk_ctrl_read: assert property (acc && !pwrite && paddr == `DALU_OFF_CTRL |->
    prdata[9:0] == ctrl_r[9:0] && prdata[14:12] == ctrl_r[14:12])
    else $error("control readback differs");
endmodule // dalu_top_checker
bind dalu_top dalu_top_checker i_dalu_top_checker (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .zero_track_flag(zero_track_flag), .link_out(link_out));

// ### testbench/tb.sv
// Self-checking bench of the decimal ALU assist
`timescale 1ns/100ps
`include "dalu_regs.vh"
`define CHK(g, x) begin check_count++; if ((g) !== (x)) begin bad_count++; \
  $display("Error t=%0t got %h exp %h", $time, (g), (x)); end end
module tb;
  // ==========================================================
  // Signals and rows: control, A, B, result, link
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, zero_track_flag, link_out, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, m;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  typedef struct {logic [15:0] c; logic [31:0] a, b, r; logic l;} dalu_row_t;
  dalu_row_t rows [27] = '{
    '{16'h0004, 32'h1234, 32'h6789, 32'h6789, 1'b0},
    '{16'h0024, 32'h1234, 32'h6789, 32'h1234, 1'b0},
    '{16'h0405, 32'h2345, 32'h6789, 32'h2789, 1'b0},
    '{16'h0805, 32'h2345, 32'h6789, 32'h2389, 1'b0},
    '{16'h0105, 32'h2345, 32'h6789, 32'h2349, 1'b0},
    '{16'h0505, 32'h2345, 32'h6789, 32'h6789, 1'b0},
    '{16'h1006, 32'h1234, 32'h6789, 32'h1789, 1'b0},
    '{16'h3106, 32'h1234, 32'h6789, 32'h1289, 1'b0},
    '{16'h2206, 32'h1234, 32'h6789, 32'h6239, 1'b0},
    '{16'h1306, 32'h1234, 32'h6789, 32'h6784, 1'b0},
    '{16'h0206, 32'h1234, 32'h6789, 32'h1234, 1'b0},
    '{16'h2207, 32'h31323334, 32'h36373839, 32'h36323339, 1'b0},
    '{16'h0007, 32'h31323334, 32'h36373839, 32'h31323334, 1'b0},
    '{16'h0040, 32'h0109, 32'h0000, 32'h676f, 1'b0},
    '{16'h0001, 32'h676f, 32'h0005, 32'h0114, 1'b0},
    '{16'h0001, 32'hab1d, 32'h9000, 32'h35b7, 1'b0},
    '{16'h0082, 32'h6789, 32'h9678, 32'hb9b8b0b2, 1'b0},
    '{16'h0092, 32'h6789, 32'h9678, 32'h39383032, 1'b0},
    '{16'h0003, 32'hb0b1b0b9, 32'h0000, 32'h0109, 1'b0},
    '{16'h0008, 32'h6666, 32'h0000, 32'h6666, 1'b1},
    '{16'h0000, 32'h6666, 32'h0000, 32'h6666, 1'b0},
    '{16'h0108, 32'h1266, 32'h0000, 32'h1266, 1'b1},
    '{16'h0208, 32'h1266, 32'h0000, 32'h1266, 1'b1},
    '{16'h0008, 32'h1266, 32'h0000, 32'h1266, 1'b0},
    '{16'h0308, 32'h1666, 32'h0000, 32'h1666, 1'b1},
    '{16'h0008, 32'h8000, 32'h8000, 32'h0000, 1'b1},
    '{16'h0008, 32'h8000, 32'h7000, 32'hf000, 1'b0}};
  dalu_top i_dalu_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .zero_track_flag(zero_track_flag), .link_out(link_out));
  dalu_seq_model i_dalu_seq_model (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // ==========================================================
  // Clock, timeout and tasks
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      test_done();
    end
  end
  task wr(input logic [7:0] a, input logic [31:0] d);
    i_dalu_seq_model.xfer(1'b1, a, d, q, e);
  endtask
  task rd(input logic [7:0] a);
    i_dalu_seq_model.xfer(1'b0, a, 32'h00000000, q, e);
  endtask
  task run(input logic [15:0] c, input logic [31:0] a, input logic [31:0] b);
    wr(`DALU_OFF_CTRL, {16'h0000, c});
    wr(`DALU_OFF_OPA, a);
    wr(`DALU_OFF_OPB, b);
    wr(`DALU_OFF_CMD, 32'h00000001);
  endtask
  task test_done;
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    `CHK({link_out, zero_track_flag}, 2'b01)
    rd(`DALU_OFF_PTRS);
    `CHK(q, `DALU_PTRS_RESET)
    rd(8'h40);
    `CHK({e, q}, {1'b1, 32'h00000000})
    foreach (rows[i]) begin
      run(rows[i].c, rows[i].a, rows[i].b);
      rd(`DALU_OFF_RESULT);
      m = (rows[i].c[2:0] == 3'h7 || rows[i].c[2:0] == 3'h2) ? 32'hffffffff : 32'h0000ffff;
      `CHK(q & m, rows[i].r)
      `CHK({link_out, zero_track_flag}, {rows[i].l, !rows[i].l})
    end
    run(16'h0000, 32'h0072, 32'h0000);
    rd(`DALU_OFF_CONV);
    `CHK(q[15:0], 16'h0057)
    run(16'h4000, 32'h9999, 32'h0000);
    rd(`DALU_OFF_CONV);
    `CHK(q[15:0], 16'h270f)
    // Slow master while shortening
    i_dalu_seq_model.idle = 2;
    wr(`DALU_OFF_CTRL, 32'h00000400);
    wr(`DALU_OFF_PTRS, 32'h08201006);
    wr(`DALU_OFF_OPA, 32'h00000001);
    wr(`DALU_OFF_CMD, 32'h0000001a);
    rd(`DALU_OFF_PTRS);
    `CHK(q, 32'h08200f05)
    rd(`DALU_OFF_CTRL);
    `CHK(q[11:8], 4'h0)
    rd(`DALU_OFF_STATUS);
    `CHK(q[4:3], 2'b10)
    wr(`DALU_OFF_CMD, 32'h00000100);
    wr(`DALU_OFF_OPA, 32'h00000010);
    wr(`DALU_OFF_CMD, 32'h00000092);
    rd(`DALU_OFF_PTRS);
    `CHK(q, 32'h081f0f05)
    rd(`DALU_OFF_STATUS);
    `CHK(q[4:3], 2'b00)
    wr(`DALU_OFF_OPA, 32'h00000012);
    wr(`DALU_OFF_CMD, 32'h000000a2);
    rd(`DALU_OFF_PTRS);
    `CHK(q, 32'h081d0f05)
    rd(`DALU_OFF_STATUS);
    `CHK(q[4:3], 2'b01)
    // Second reset in mid-run
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`DALU_OFF_CTRL);
    `CHK(q, 32'h00000000)
    // Sticky not-equal was set before the reset and must be gone
    rd(`DALU_OFF_STATUS);
    `CHK(q, 32'h00000004)
    rd(`DALU_OFF_PTRS);
    `CHK(q, `DALU_PTRS_RESET)
    test_done();
  end
endmodule // tb
